// [core/ccs_chan_ctl.sv]
/*
 * Start/stop sequencing of one converter or sequencer channel.
 * Assumes done pulses for one cycle when the running conversion or
 * sequence finishes.
 */
`timescale 1ns/1ns
module ccs_chan_ctl (
   input wire logic pclk,
   input wire logic presetn,
   input wire ccs_pkg::ccs_req_t req,
   input wire logic done,
   output ccs_pkg::ccs_chan_t st
);

   ccs_pkg::ccs_chan_t st_r;
   ccs_pkg::ccs_chan_t st_nxt;

   // ==========================================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.start_r = 1'b0;
      if (!req.enable) begin
         st_nxt.run_r = 1'b0;
         st_nxt.pend_r = 1'b0;
      end else if (req.start_wr) begin
         // start wins over stop and aborts the ongoing work
         st_nxt.start_r = 1'b1; // R3 R5 R8 R9 R11 R13 R14
         st_nxt.run_r = req.continuous;
         st_nxt.pend_r = 1'b0;
      end else begin
         if (req.stop_wr && req.continuous && st_r.run_r) begin // R1 R2 R6 R7 R12
            st_nxt.pend_r = 1'b1;
         end
         // stop lands when the work in progress completes
         if (done && (st_r.pend_r || (req.stop_wr && req.continuous))) begin // R4
            st_nxt.run_r = 1'b0;
            st_nxt.pend_r = 1'b0;
         end
         if (!req.continuous) begin
            st_nxt.run_r = 1'b0;
            st_nxt.pend_r = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign st = st_r;

endmodule

// [core/ccs_pkg.sv]
/*
 * Shared constants and types of the conversion start/stop control block:
 * register byte addresses, field positions, reset values and the per-channel
 * control carrier.
 * Assumes a 32-bit APB with one aligned word per register.
 */
package ccs_pkg;

   // ==========================================================================
   // register map
   localparam logic [11:0] CCS_IDX_CTRL = 12'h009;
   localparam logic [11:0] CCS_IDX_CFG = 12'h00A;
   localparam logic [11:0] CCS_IDX_STAT = 12'h00B;
   localparam logic [11:0] CCS_ADDR_CTRL = 12'(CCS_IDX_CTRL * 4);
   localparam logic [11:0] CCS_ADDR_CFG = 12'(CCS_IDX_CFG * 4);
   localparam logic [11:0] CCS_ADDR_STAT = 12'(CCS_IDX_STAT * 4);

   // ==========================================================================
   // control register fields
   localparam int CCS_BIT_A_START = 14;
   localparam int CCS_BIT_B_START = 12;
   localparam int CCS_BIT_A_STOP = 10;
   localparam int CCS_BIT_B_STOP = 8;
   localparam int CCS_BIT_SEQ_START = 6;
   localparam int CCS_BIT_SEQ_STOP = 2;
   localparam logic [15:0] CCS_CTRL_RESET = 16'h0000;

   // ==========================================================================
   // configuration register fields
   localparam int CCS_BIT_A_CONT = 0;
   localparam int CCS_BIT_B_CONT = 1;
   localparam int CCS_BIT_A_EN = 2;
   localparam int CCS_BIT_B_EN = 3;
   localparam logic [3:0] CCS_CFG_RESET = 4'h0;

   // ==========================================================================
   // status register fields
   localparam int CCS_STAT_RUN_LSB = 0;
   localparam int CCS_STAT_PEND_LSB = 4;

   // ==========================================================================
   // channel numbering
   localparam int CCS_NCH = 3;
   localparam int CCS_CH_A = 0;
   localparam int CCS_CH_B = 1;
   localparam int CCS_CH_SEQ = 2;

   // one channel's request from the register file
   typedef struct packed {
      logic start_wr;
      logic stop_wr;
      logic continuous;
      logic enable;
   } ccs_req_t;

   // one channel's state
   typedef struct packed {
      logic start_r;
      logic run_r;
      logic pend_r;
   } ccs_chan_t;

   // register file state
   typedef struct packed {
      logic [3:0] cfg_r;
      logic [31:0] prdata_r;
      logic pslverr_r;
   } ccs_regs_t;

endpackage

// [core/ccs_top.sv]
/*
 * Conversion start/stop control with its APB register file: control,
 * configuration and status registers, plus three channel sequencers for
 * two shunt converters and the multiplexed converter's channel sequence.
 * Assumes the converters pulse done when a conversion or a sequence ends,
 * and treat start as abort-and-restart.
 */
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ns

// Functional notes
// R1: shunt A stop ends continuous run after conversion
// R2: shunt A stop ignored in single-shot mode
// R3: shunt A start beats stop in one write
// R4: shunt A pending stop clears on finish or start
// R5: shunt A start aborts and restarts conversions
// R6: shunt B stop ends continuous run after conversion
// R7: shunt B stop ignored in single-shot mode
// R8: shunt B start beats stop in one write
// R9: shunt B start aborts, restarts, clears stop
// R10: shunt B start needs enable, reads zero
// R11: sequence start restarts sequence, reads zero
// R12: sequence stop waits for sequence end
// R13: sequence start aborts and clears pending stop
// R14: sequence start beats stop in one write
// R15: reserved control bits read zero, ignore writes
module ccs_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic [2:0] chan_done,
   output logic [2:0] chan_start,
   output logic [2:0] chan_run
);

   ccs_pkg::ccs_regs_t rg_r;
   ccs_pkg::ccs_regs_t rg_nxt;
   ccs_pkg::ccs_req_t req [ccs_pkg::CCS_NCH];
   ccs_pkg::ccs_chan_t cst [ccs_pkg::CCS_NCH];
   logic setup;
   logic wr_acc;
   logic ctrl_wr;
   logic [2:0] start_bits;
   logic [2:0] stop_bits;
   logic [2:0] cont;
   logic [2:0] en;
   logic [2:0] pend;
   logic [2:0] run;

   // ==========================================================================
   // address decode
   function automatic logic addr_known(input logic [11:0] a);
      addr_known = (a == ccs_pkg::CCS_ADDR_CTRL) || (a == ccs_pkg::CCS_ADDR_CFG) ||
                   (a == ccs_pkg::CCS_ADDR_STAT);
   endfunction

   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign ctrl_wr = wr_acc && (paddr == ccs_pkg::CCS_ADDR_CTRL);

   // only the six documented fields are looked at; the rest are dropped
   assign start_bits = {pwdata[ccs_pkg::CCS_BIT_SEQ_START],
                        pwdata[ccs_pkg::CCS_BIT_B_START],
                        pwdata[ccs_pkg::CCS_BIT_A_START]}; // R15
   assign stop_bits = {pwdata[ccs_pkg::CCS_BIT_SEQ_STOP],
                       pwdata[ccs_pkg::CCS_BIT_B_STOP],
                       pwdata[ccs_pkg::CCS_BIT_A_STOP]}; // R15

   // the sequencer always runs until told to stop
   assign cont = {1'b1, rg_r.cfg_r[ccs_pkg::CCS_BIT_B_CONT], rg_r.cfg_r[ccs_pkg::CCS_BIT_A_CONT]};
   assign en = {1'b1, rg_r.cfg_r[ccs_pkg::CCS_BIT_B_EN], rg_r.cfg_r[ccs_pkg::CCS_BIT_A_EN]}; // R10

   // ==========================================================================
   // channel sequencers
   generate
      for (genvar i = 0; i < ccs_pkg::CCS_NCH; i++) begin : g_ch
         always_comb begin
            req[i].start_wr = ctrl_wr && start_bits[i]; // R3 R8 R14
            req[i].stop_wr = ctrl_wr && stop_bits[i]; // R1 R2 R6 R7 R12
            req[i].continuous = cont[i];
            req[i].enable = en[i];
         end

         // start aborts and restarts; a pending stop completes on done
         ccs_chan_ctl u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .req(req[i]),
            .done(chan_done[i]),
            .st(cst[i])
         ); // R4 R5 R9 R11 R13

         assign chan_start[i] = cst[i].start_r;
         assign chan_run[i] = cst[i].run_r;
         assign pend[i] = cst[i].pend_r;
         assign run[i] = cst[i].run_r;
      end
   endgenerate

   // ==========================================================================
   // register file
   always_comb begin
      rg_nxt = rg_r;
      if (wr_acc && (paddr == ccs_pkg::CCS_ADDR_CFG)) begin
         rg_nxt.cfg_r = pwdata[3:0];
      end
      if (setup) begin
         rg_nxt.prdata_r = 32'h0000_0000;
         rg_nxt.pslverr_r = !addr_known(paddr);
         if (!pwrite) begin
            unique case (paddr)
               ccs_pkg::CCS_ADDR_CTRL: begin
                  // start bits and reserved bits read zero
                  rg_nxt.prdata_r[ccs_pkg::CCS_BIT_A_STOP] = pend[ccs_pkg::CCS_CH_A]; // R10 R11 R15
                  rg_nxt.prdata_r[ccs_pkg::CCS_BIT_B_STOP] = pend[ccs_pkg::CCS_CH_B];
                  rg_nxt.prdata_r[ccs_pkg::CCS_BIT_SEQ_STOP] = pend[ccs_pkg::CCS_CH_SEQ];
               end
               ccs_pkg::CCS_ADDR_CFG: begin
                  rg_nxt.prdata_r[3:0] = rg_r.cfg_r;
               end
               ccs_pkg::CCS_ADDR_STAT: begin
                  rg_nxt.prdata_r[ccs_pkg::CCS_STAT_RUN_LSB +: 3] = run;
                  rg_nxt.prdata_r[ccs_pkg::CCS_STAT_PEND_LSB +: 3] = pend;
               end
               default: begin
                  rg_nxt.prdata_r = 32'h0000_0000;
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rg_r.cfg_r <= ccs_pkg::CCS_CFG_RESET;
         rg_r.prdata_r <= 32'h0000_0000;
         rg_r.pslverr_r <= 1'b0;
      end else begin
         rg_r <= rg_nxt;
      end
   end

   // zero wait states: data are latched in the setup cycle
   assign pready = 1'b1;
   assign prdata = rg_r.prdata_r;
   assign pslverr = rg_r.pslverr_r && psel && penable;

endmodule

// [verification/ccs_conv_model.sv]
/* converter and sequencer model: runs LAT cycles per conversion.
   assumes chan_start and chan_run from ccs_top. */
`timescale 1ns/1ns
module ccs_conv_model #(parameter int LAT = 20) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] chan_start,
   input wire logic [2:0] chan_run,
   output logic [2:0] chan_done
);
   // ==========================================
   // per channel counters
   logic [7:0] cnt [3];
   logic [2:0] ss;
   always_comb begin
      for (int i = 0; i < 3; i++) chan_done[i] = cnt[i] == 8'h01 && (chan_run[i] || ss[i]);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      for (int i = 0; i < 3; i++) begin
         if (!presetn) begin
            cnt[i] <= 8'h00;
            ss[i] <= 1'b0;
         end else if (chan_start[i]) begin
            cnt[i] <= 8'(LAT);
            ss[i] <= !chan_run[i];
         end else if (cnt[i] != 8'h00 && (chan_run[i] || ss[i])) begin
            cnt[i] <= (cnt[i] == 8'h01 && chan_run[i]) ? 8'(LAT) : cnt[i] - 8'h01;
         end else begin
            cnt[i] <= 8'h00;
         end
      end
   end
endmodule

// [verification/ccs_top_monitor.sv]
/* ccs_top port checker, bound into every ccs_top.
   assumes one pclk domain and async presetn. */
`timescale 1ns/1ns
module ccs_top_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic [2:0] chan_done,
   input wire logic [2:0] chan_start,
   input wire logic [2:0] chan_run
);
   // ==========================================
   // properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic cfg_wr;
   assign acc = psel && penable;
   assign cfg_wr = acc && pwrite && paddr == ccs_pkg::CCS_ADDR_CFG;
   sequence s_wr(b);
      acc && pwrite && paddr == ccs_pkg::CCS_ADDR_CTRL && pwdata[b];
   endsequence
   AST_SEQ_START: assert property (s_wr(6) |=> chan_start[2] && chan_run[2]) else $error("no sequence start");
   AST_SEQ_CAUSE: assert property (chan_start[2] |-> $past(acc && pwrite && paddr == ccs_pkg::CCS_ADDR_CTRL && pwdata[6]))
      else $error("stray start");
   AST_START_WIN: assert property (s_wr(6) ##0 s_wr(2) |=> chan_run[2]) else $error("stop beat start");
   AST_PULSE: assert property (chan_start != 0 |=> (chan_start & $past(chan_start)) == 3'h0) else $error("long pulse");
   AST_SEQ_FALL: assert property ($fell(chan_run[2]) |-> $past(chan_done[2])) else $error("early seq end");
   AST_A_FALL: assert property ($fell(chan_run[0]) |-> $past(chan_done[0]) || $past(cfg_wr, 2))
      else $error("early A end");
   AST_B_FALL: assert property ($fell(chan_run[1]) |-> $past(chan_done[1]) || $past(cfg_wr, 2))
      else $error("early B end");
   AST_CTRL_RD: assert property (acc && !pwrite && paddr == ccs_pkg::CCS_ADDR_CTRL |-> (prdata & ~32'h00000504) == 0)
      else $error("ctrl readback bits");
   AST_ERR: assert property (acc && paddr > ccs_pkg::CCS_ADDR_STAT |-> pslverr) else $error("no slave error");
endmodule
bind ccs_top ccs_top_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
   .pslverr, .chan_done, .chan_start, .chan_run);

// [verification/ccs_top_tb.sv]
/* self-checking bench of ccs_top through APB tasks.
   assumes ccs_conv_model on the converter side. */
`timescale 1ns/1ns
module ccs_top_tb;
   // ==========================================
   // bench
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0] chan_done, chan_start, chan_run;
   int n_fail = 0;
   int n_tests = 0;
   int sb [3] = '{ccs_pkg::CCS_BIT_A_START, ccs_pkg::CCS_BIT_B_START, ccs_pkg::CCS_BIT_SEQ_START};
   int pb [3] = '{ccs_pkg::CCS_BIT_A_STOP, ccs_pkg::CCS_BIT_B_STOP, ccs_pkg::CCS_BIT_SEQ_STOP};
   ccs_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
      .chan_done, .chan_start, .chan_run);
   ccs_conv_model i_conv (.pclk, .presetn, .chan_start, .chan_run, .chan_done);
   task automatic stop_test;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h00000000, q, e);
      chk(q, exp);
   endtask
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      #200000;
      n_fail++;
      stop_test();
   end
   initial begin
      logic [31:0] q;
      logic e;
      int t;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(ccs_pkg::CCS_ADDR_CTRL, 32'h00000000);
      wr(ccs_pkg::CCS_ADDR_CFG, 32'h0000000F);
      rd(ccs_pkg::CCS_ADDR_CFG, 32'h0000000F);
      for (int i = 0; i < 3; i++) begin
         wr(ccs_pkg::CCS_ADDR_CTRL, 32'h1 << sb[i]);
         #1 chk(32'(chan_start[i] & chan_run[i]), 32'h1);
         wr(ccs_pkg::CCS_ADDR_CTRL, 32'h1 << pb[i]);
         rd(ccs_pkg::CCS_ADDR_CTRL, 32'h1 << pb[i]);
         rd(ccs_pkg::CCS_ADDR_STAT, (((32'h1 << (i + 1)) - 32'h1) << ccs_pkg::CCS_STAT_RUN_LSB) |
            (32'h1 << (i + ccs_pkg::CCS_STAT_PEND_LSB)));
         #1 chk(32'(chan_run[i]), 32'h1);
         t = 0;
         do @(negedge pclk); while (chan_done[i] !== 1'b1 && ++t < 60);
         chk(32'(chan_done[i]), 32'h1);
         @(posedge pclk);
         #1 chk(32'(chan_run[i]), 32'h0);
         rd(ccs_pkg::CCS_ADDR_CTRL, 32'h00000000);
         wr(ccs_pkg::CCS_ADDR_CTRL, (32'h1 << sb[i]) | (32'h1 << pb[i]));
         #1 chk(32'(chan_start[i] & chan_run[i]), 32'h1);
         rd(ccs_pkg::CCS_ADDR_CTRL, 32'h00000000);
         wr(ccs_pkg::CCS_ADDR_CTRL, 32'h1 << pb[i]);
         wr(ccs_pkg::CCS_ADDR_CTRL, 32'h1 << sb[i]);
         #1 chk(32'(chan_start[i] & chan_run[i]), 32'h1);
         rd(ccs_pkg::CCS_ADDR_CTRL, 32'h00000000);
      end
      wr(ccs_pkg::CCS_ADDR_CFG, 32'h0000000C);
      @(posedge pclk);
      #1 chk(32'(chan_run), 32'h4);
      wr(ccs_pkg::CCS_ADDR_CTRL, 32'h00004000);
      #1 chk(32'({chan_start[0], chan_run[0]}), 32'h2);
      wr(ccs_pkg::CCS_ADDR_CTRL, 32'h00000500);
      rd(ccs_pkg::CCS_ADDR_CTRL, 32'h00000000);
      wr(ccs_pkg::CCS_ADDR_CFG, 32'h00000000);
      wr(ccs_pkg::CCS_ADDR_CTRL, 32'h00001000);
      #1 chk(32'(chan_start[1]), 32'h0);
      wr(ccs_pkg::CCS_ADDR_CFG, 32'h0000000F);
      wr(ccs_pkg::CCS_ADDR_CTRL, 32'hFFFFFFFF);
      rd(ccs_pkg::CCS_ADDR_CTRL, 32'h00000000);
      apb(1'b0, 12'h3F0, 32'h00000000, q, e);
      chk({q[31:1], e}, 32'h1);
      stop_test();
   end
endmodule
